// File: hw/fcr_pkg.sv
/*
 * Shared constants of the fiber control and port interrupt summary block:
 * register numbers, page numbers, field positions, reset values, mode codes
 * and the length of the fiber soft reset.
 * Assumes a 16-bit paged management register space with 5-bit register numbers.
 */
package fcr_pkg;
    // Register numbers and pages
    localparam logic [4:0] FCR_REG_FIBER_CTRL = 5'h00;
    localparam logic [4:0] FCR_REG_PAGE_SEL = 5'h16;
    localparam logic [4:0] FCR_REG_IRQ_SUM = 5'h17;
    localparam logic [7:0] FCR_PAGE_FIBER = 8'h01;
    localparam logic [7:0] FCR_PAGE_COPPER = 8'h00;
    localparam logic [7:0] FCR_PAGE_RST = 8'h00;
    // Fiber control field positions and port count
    localparam int FCR_B_RESET = 15;
    localparam int FCR_B_LOOPBACK = 14;
    localparam int FCR_B_SPD_LSB = 13;
    localparam int FCR_B_ANEG_EN = 12;
    localparam int FCR_B_PWR_DN = 11;
    localparam int FCR_B_RESTART = 9;
    localparam int FCR_B_DUPLEX = 8;
    localparam int FCR_B_SPD_MSB = 6;
    localparam int FCR_PORTS = 4;
    // Reset values
    localparam logic FCR_RST_DUPLEX = 1'b1;
    localparam logic [1:0] FCR_RST_SPEED = 2'b10;
    // Fiber mode field codes
    localparam logic [1:0] FCR_MODE_100FX = 2'b00;
    localparam logic [1:0] FCR_MODE_1000X = 2'b01;
    localparam logic [1:0] FCR_MODE_AUTO = 2'b10;
    localparam logic [1:0] FCR_MODE_SW = 2'b11;
    // Speed codes as {bit6, bit13}
    localparam logic [1:0] FCR_SPD_1000 = 2'b10;
    localparam logic [1:0] FCR_SPD_100 = 2'b01;
    localparam logic [1:0] FCR_SPD_10 = 2'b00;
    // Fiber soft reset length in clock cycles
    localparam logic [3:0] FCR_SRST_CYCLES = 4'h4;
endpackage

// File: hw/fcr_link_if.sv
/*
 * Carrier between the fiber control top and its two helpers: soft reset
 * sequencer handshake and the registered per-port interrupt summary.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/1ps
interface fcr_link_if;
    logic srst_start;
    logic srst_busy;
    logic [3:0] irq_sum;

    modport ctrl (output srst_start, input srst_busy, input irq_sum);
    modport seq (input srst_start, output srst_busy);
    modport irq (output irq_sum);
endinterface

// File: hw/fcr_srst_seq.sv
/*
 * Fiber soft reset sequencer: a start pulse holds busy for a fixed number of
 * cycles. Assumes start comes from the control register logic.
 */
`timescale 1ns/1ps
module fcr_srst_seq
    import fcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    fcr_link_if.seq lnk
);
    typedef struct packed {
        logic busy;
        logic [3:0] cnt;
    } fcr_seq_s;

    fcr_seq_s s_r;
    fcr_seq_s s_nxt;

    // Count down; a new start reloads so no request is lost
    always_comb begin
        s_nxt = s_r;
        if (lnk.srst_start) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = FCR_SRST_CYCLES - 4'h1;
        end else if (s_r.busy) begin
            if (s_r.cnt == 4'h0) begin
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt - 4'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.srst_busy = s_r.busy;

    property p_srst_len;
        @(posedge clk_i) disable iff (!resetn_i)
        lnk.srst_start ##1 !lnk.srst_start [*4] |-> s_r.busy ##0 $past(s_r.busy, 3) ##1 !s_r.busy;
    endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
    c_srst: cover property (@(posedge clk_i) disable iff (!resetn_i) $fell(s_r.busy));
endmodule

// File: hw/fcr_irq_sum.sv
/*
 * Per-port interrupt summary: registers the active level of each port's
 * interrupt. Assumes port interrupt levels are synchronous to the clock.
 */
`timescale 1ns/1ps
module fcr_irq_sum
    import fcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [FCR_PORTS-1:0] port_irq_i,
    fcr_link_if.irq lnk
);
    typedef struct packed {
        logic [FCR_PORTS-1:0] act;
    } fcr_irq_s;

    fcr_irq_s s_r;
    fcr_irq_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < FCR_PORTS; i++) begin
            s_nxt.act[i] = port_irq_i[i];
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.irq_sum = s_r.act;
endmodule

// File: hw/fcr_top.sv
/*
 * Fiber control register (page 1, register 0), page select (register 22)
 * and global per-port interrupt summary (page 0, register 23).
 * Assumes a management engine that presents one-cycle read and write strobes
 * with a register number, synchronous to CLK_I; read data follow one cycle later.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Summary register gives one active bit per port in 3:0, upper bits zero.
// - Writing reset bit starts fiber reset at once; bit clears when done.
// - Loopback bit loops transmit to receive and drops the fiber link.
// - Loopback runs at 1000 in 1000BASE-X, 100 in 100BASE-FX.
// - Speed LSB is forced, speed-derived or writable by fiber mode.
// - Speed MSB is forced, speed-derived or writable by fiber mode.
// - Changing autoneg enable breaks link, restarts autoneg, sets restart bit.
// - Autoneg enable has no effect in 100BASE-FX mode.
// - Autoneg enable loads its strap on hardware reset, kept by soft reset.
// - Leaving power down performs fiber reset and autoneg restart.
// - Power down loads strap gated by configuration mode; soft reset clears it.
// - Isolate bit reads zero and does nothing.
// - Restart bit self-clears; restart follows hardware, soft reset, enable change.
// - Duplex applies only on reset, restart, enable change, power up; resets full.
// - Collision test bit and bits 5:0 read zero.
// - Fiber mode 01 selects 1000BASE-X.
// - Fiber mode 00 is 100BASE-X without autoneg.
module fcr_top
    import fcr_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Management register access
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [4:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    // Straps and configuration
    input wire logic POWER_DOWN_STRAP_I,
    input wire logic AUTONEG_ENABLE_STRAP_I,
    input wire logic [2:0] HW_CONFIG_MODE_I,
    input wire logic [1:0] FIBER_MODE_I,
    input wire logic [1:0] LINK_SPEED_I,
    // Port interrupt levels
    input wire logic [3:0] PORT_IRQ_I,
    // Fiber datapath control
    output logic FIBER_RESET_O,
    output logic LOOPBACK_O,
    output logic [1:0] LOOPBACK_SPEED_O,
    output logic LINK_DROP_O,
    output logic ANEG_ENABLE_O,
    output logic ANEG_RESTART_O,
    output logic POWER_DOWN_O,
    output logic DUPLEX_O,
    output logic [1:0] SPEED_SEL_O
);
    typedef struct packed {
        logic strap_pend;
        logic loopback;
        logic aneg_en;
        logic pwr_dn;
        logic restart;
        logic dup_wr;
        logic dup_act;
        logic [1:0] spd_wr;
        logic [7:0] page;
        logic [15:0] rdata;
        logic rvalid;
        logic link_drop;
        logic aneg_eff;
        logic [1:0] spd_eff;
        logic [1:0] lb_spd;
    } fcr_state_s;

    fcr_state_s s_r;
    fcr_state_s s_nxt;
    fcr_link_if lnk ();

    logic wr_fcr;
    logic wr_page;
    logic rd_fcr;
    logic rd_sum;
    logic pd_exit;
    logic en_change;
    logic sreset_go;
    logic restart_evt;
    logic fx_mode;
    logic pd_mode_ok;
    logic [1:0] spd_view;
    logic [15:0] fcr_view;

    // Helpers
    fcr_srst_seq u_seq (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .lnk(lnk.seq)
    );
    fcr_irq_sum u_irq (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .port_irq_i(PORT_IRQ_I),
        .lnk(lnk.irq)
    );

    assign wr_fcr = REG_WR_I && REG_ADDR_I == FCR_REG_FIBER_CTRL && s_r.page == FCR_PAGE_FIBER;
    assign rd_fcr = REG_ADDR_I == FCR_REG_FIBER_CTRL && s_r.page == FCR_PAGE_FIBER;
    assign rd_sum = REG_ADDR_I == FCR_REG_IRQ_SUM && s_r.page == FCR_PAGE_COPPER;
    assign wr_page = REG_WR_I && REG_ADDR_I == FCR_REG_PAGE_SEL;
    assign fx_mode = FIBER_MODE_I == FCR_MODE_100FX;
    assign pd_mode_ok = HW_CONFIG_MODE_I[2:1] == 2'b01 || HW_CONFIG_MODE_I[2:1] == 2'b11
        || HW_CONFIG_MODE_I == 3'b100;
    assign pd_exit = wr_fcr && s_r.pwr_dn && !REG_WDATA_I[FCR_B_PWR_DN];
    assign en_change = wr_fcr && REG_WDATA_I[FCR_B_ANEG_EN] != s_r.aneg_en;
    // soft reset on write or power up
    assign sreset_go = (wr_fcr && REG_WDATA_I[FCR_B_RESET]) || pd_exit;
    assign restart_evt = s_r.strap_pend || sreset_go || (en_change && !fx_mode)
        || (wr_fcr && REG_WDATA_I[FCR_B_RESTART]);
    assign lnk.srst_start = sreset_go;

    always_comb begin
        unique case (FIBER_MODE_I)
            FCR_MODE_100FX: spd_view = FCR_SPD_100;
            FCR_MODE_1000X: spd_view = FCR_SPD_1000;
            FCR_MODE_AUTO: spd_view = {LINK_SPEED_I == FCR_SPD_1000, LINK_SPEED_I == FCR_SPD_100};
            FCR_MODE_SW: spd_view = s_r.spd_wr;
        endcase
    end

    // read view with forced bits; bits zero
    always_comb begin
        fcr_view = 16'h0000;
        fcr_view[FCR_B_RESET] = lnk.srst_busy;
        fcr_view[FCR_B_LOOPBACK] = s_r.loopback;
        fcr_view[FCR_B_SPD_LSB] = spd_view[0];
        fcr_view[FCR_B_ANEG_EN] = s_r.aneg_en;
        fcr_view[FCR_B_PWR_DN] = s_r.pwr_dn;
        fcr_view[FCR_B_RESTART] = s_r.restart;
        fcr_view[FCR_B_DUPLEX] = s_r.dup_wr;
        fcr_view[FCR_B_SPD_MSB] = spd_view[1];
    end

    // Next state of control, read path and outputs
    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.restart = restart_evt;
        if (s_r.strap_pend) begin
            s_nxt.aneg_en = AUTONEG_ENABLE_STRAP_I;
            s_nxt.pwr_dn = POWER_DOWN_STRAP_I && pd_mode_ok;
            s_nxt.strap_pend = 1'b0;
        end else if (wr_fcr) begin
            s_nxt.loopback = REG_WDATA_I[FCR_B_LOOPBACK];
            s_nxt.aneg_en = REG_WDATA_I[FCR_B_ANEG_EN];
            s_nxt.pwr_dn = REG_WDATA_I[FCR_B_PWR_DN];
            s_nxt.dup_wr = REG_WDATA_I[FCR_B_DUPLEX];
            // speed writable only in mode 11
            if (FIBER_MODE_I == FCR_MODE_SW) begin
                s_nxt.spd_wr = {REG_WDATA_I[FCR_B_SPD_MSB], REG_WDATA_I[FCR_B_SPD_LSB]};
            end
        end
        // soft reset clears loopback and power down
        if (sreset_go) begin
            s_nxt.loopback = 1'b0;
            s_nxt.pwr_dn = 1'b0;
        end
        // duplex applied on its events only
        if (restart_evt) begin
            s_nxt.dup_act = s_nxt.dup_wr;
        end
        if (wr_page) begin
            s_nxt.page = REG_WDATA_I[7:0];
        end
        // summary in low bits, upper zero
        if (REG_RD_I) begin
            s_nxt.rvalid = 1'b1;
            if (rd_fcr) begin
                s_nxt.rdata = fcr_view;
            end else if (rd_sum) begin
                s_nxt.rdata = {12'h000, lnk.irq_sum};
            end else if (REG_ADDR_I == FCR_REG_PAGE_SEL) begin
                s_nxt.rdata = {8'h00, s_r.page};
            end else begin
                s_nxt.rdata = 16'h0000;
            end
        end
        // link drops with loopback, reset, restart or power down
        s_nxt.link_drop = s_nxt.loopback || sreset_go || lnk.srst_busy || s_nxt.restart || s_nxt.pwr_dn;
        s_nxt.aneg_eff = s_nxt.aneg_en && !fx_mode;
        s_nxt.spd_eff = spd_view;
        // loopback rate from fiber mode; mode decode
        if (FIBER_MODE_I == FCR_MODE_1000X) begin
            s_nxt.lb_spd = FCR_SPD_1000;
        end else if (fx_mode) begin
            s_nxt.lb_spd = FCR_SPD_100;
        end else begin
            s_nxt.lb_spd = spd_view;
        end
    end

    // State register; straps are caught on the first edge after release
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_r <= '0;
            s_r.strap_pend <= 1'b1;
            s_r.dup_wr <= FCR_RST_DUPLEX;
            s_r.dup_act <= FCR_RST_DUPLEX;
            s_r.spd_wr <= FCR_RST_SPEED;
            s_r.page <= FCR_PAGE_RST;
            s_r.link_drop <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA_O = s_r.rdata;
    assign REG_RVALID_O = s_r.rvalid;
    assign FIBER_RESET_O = lnk.srst_busy;
    assign LOOPBACK_O = s_r.loopback;
    assign LOOPBACK_SPEED_O = s_r.lb_spd;
    assign LINK_DROP_O = s_r.link_drop;
    assign ANEG_ENABLE_O = s_r.aneg_eff;
    assign ANEG_RESTART_O = s_r.restart;
    assign POWER_DOWN_O = s_r.pwr_dn;
    assign DUPLEX_O = s_r.dup_act;
    assign SPEED_SEL_O = s_r.spd_eff;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_irq_sum;
        REG_RD_I && rd_sum |=> REG_RDATA_O == {12'h000, $past(lnk.irq_sum)};
    endproperty
    a_irq_sum: assert property (p_irq_sum) else $error("summary read wrong");

    property p_srst_start;
        wr_fcr && REG_WDATA_I[15] |=> FIBER_RESET_O ##0 !LOOPBACK_O ##0 ANEG_RESTART_O;
    endproperty
    a_srst_start: assert property (p_srst_start) else $error("soft reset not started");

    property p_lb_drop;
        LOOPBACK_O |-> LINK_DROP_O;
    endproperty
    a_lb_drop: assert property (p_lb_drop) else $error("link up during loopback");

    property p_lb_speed;
        FIBER_MODE_I == 2'b01 ##1 FIBER_MODE_I == 2'b01 |-> LOOPBACK_SPEED_O == 2'b10;
    endproperty
    a_lb_speed: assert property (p_lb_speed) else $error("loopback rate wrong");

    property p_spd_fx;
        REG_RD_I && rd_fcr && fx_mode |=> REG_RDATA_O[13] && !REG_RDATA_O[6];
    endproperty
    a_spd_fx: assert property (p_spd_fx) else $error("forced speed wrong");

    property p_en_change;
        en_change && !fx_mode && !s_r.strap_pend |=> ANEG_RESTART_O && LINK_DROP_O ##1 !ANEG_RESTART_O;
    endproperty
    a_en_change: assert property (p_en_change) else $error("enable change no restart");

    property p_fx_aneg;
        fx_mode |=> !ANEG_ENABLE_O;
    endproperty
    a_fx_aneg: assert property (p_fx_aneg) else $error("autoneg active in FX");

    property p_pd_exit;
        pd_exit |=> FIBER_RESET_O && ANEG_RESTART_O && !POWER_DOWN_O;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power up no reset");

    property p_straps;
        s_r.strap_pend |=> POWER_DOWN_O == $past(POWER_DOWN_STRAP_I && pd_mode_ok)
            && s_r.aneg_en == $past(AUTONEG_ENABLE_STRAP_I) && ANEG_RESTART_O;
    endproperty
    a_straps: assert property (p_straps) else $error("strap load wrong");

    property p_zero_bits;
        REG_RD_I && rd_fcr |=> REG_RDATA_O[10] == 1'b0 && REG_RDATA_O[7] == 1'b0 && REG_RDATA_O[5:0] == 6'h00;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("reserved bits nonzero");

    property p_dup_hold;
        !restart_evt |=> DUPLEX_O == $past(DUPLEX_O);
    endproperty
    a_dup_hold: assert property (p_dup_hold) else $error("duplex changed early");

    c_loopback: cover property (wr_fcr && REG_WDATA_I[14]);
    c_pd_exit: cover property (pd_exit);
    c_irq_read: cover property (REG_RD_I && rd_sum && lnk.irq_sum != 4'h0);
endmodule

// File: verif/fcr_mgmt_model.sv
/*
 * Management controller model: register write, register read and page select.
 * Assumes the block takes strobes at a rising edge and answers one cycle later.
 */
`timescale 1ns/1ps
module fcr_mgmt_model
    import fcr_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Register strobes
    output logic wr_o,
    output logic rd_o,
    output logic [4:0] addr_o,
    output logic [15:0] wdata_o,
    // Read answer
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i
);
    // Idle bus
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 5'h1f;
        wdata_o = 16'hffff;
    end

    // One write held over its taking edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d; // Released data is no longer meaningful
    endtask

    // One read, data taken with the valid pulse
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_i);
        #1;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask

    task automatic page(input logic [7:0] p);
        wr(FCR_REG_PAGE_SEL, {8'h00, p});
    endtask
endmodule

// File: verif/tb_top.sv
/*
 * Self-checking bench of the fiber control and port summary block.
 * Assumes the management model drives the register strobes.
 */
`timescale 1ns/1ps
module tb_top;
    import fcr_pkg::*;
    logic clk = 1'b0;
    logic rst_n, pd_strap, an_strap, wr, rd, rvalid;
    logic [2:0] cfg_mode;
    logic [1:0] fib_mode, link_spd, lpbk_spd, spd;
    logic [3:0] port_irq;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, r;
    logic fib_rst, lpbk, link_drop, aneg_en, aneg_rst, pdn, dup;
    int err_count = 0;
    int cmp_count = 0;

    // Clock 40 MHz
    always #12.5 clk = ~clk;

    fcr_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .POWER_DOWN_STRAP_I(pd_strap),
        .AUTONEG_ENABLE_STRAP_I(an_strap), .HW_CONFIG_MODE_I(cfg_mode), .FIBER_MODE_I(fib_mode),
        .LINK_SPEED_I(link_spd), .PORT_IRQ_I(port_irq), .FIBER_RESET_O(fib_rst), .LOOPBACK_O(lpbk),
        .LOOPBACK_SPEED_O(lpbk_spd), .LINK_DROP_O(link_drop), .ANEG_ENABLE_O(aneg_en),
        .ANEG_RESTART_O(aneg_rst), .POWER_DOWN_O(pdn), .DUPLEX_O(dup), .SPEED_SEL_O(spd));

    fcr_mgmt_model i_mgmt (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
        .rdata_i(rdata), .rvalid_i(rvalid));

    // Compare helpers
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_word({15'h0000, got}, {15'h0000, exp}, m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic hreset(input logic [2:0] m);
        rst_n = 1'b0;
        cfg_mode = m;
        an_strap = ~m[0];
        cyc(16);
        rst_n = 1'b1;
        cyc(1);
    endtask

    task automatic t_hw_reset;
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i + 3);
            hreset(m);
            chk_bit(pdn, (m[2:1] == 2'b01) || (m[2:1] == 2'b11) || (m == 3'b100), "power_down_strap strap");
            chk_bit(aneg_en, ~m[0], "aneg strap");
            chk_bit(dup, 1'b1, "duplex reset");
        end
        i_mgmt.page(FCR_PAGE_FIBER);
        i_mgmt.rd(FCR_REG_PAGE_SEL, r);
        chk_word(r, {8'h00, FCR_PAGE_FIBER}, "page readback");
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word(r, 16'h1940, "ctrl after reset");
        $display("test hw_reset done");
    endtask

    task automatic t_power_down_strap_exit;
        int n;
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h1000);
        chk_bit(pdn, 1'b0, "power up");
        chk_bit(aneg_rst, 1'b1, "restart on power up");
        chk_bit(dup, 1'b0, "duplex on power up");
        n = 0;
        for (int k = 0; k < 8; k++) begin
            n += int'(fib_rst === 1'b1);
            cyc(1);
            if (k == 0) begin
                chk_bit(aneg_rst, 1'b0, "restart pulse length");
            end
        end
        chk_word(16'(n), 16'(FCR_SRST_CYCLES), "soft reset length");
        $display("test power_down_strap_exit done");
    endtask

    task automatic t_duplex;
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h1100);
        cyc(3);
        chk_bit(dup, 1'b0, "duplex deferred");
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h1300);
        chk_bit(aneg_rst, 1'b1, "restart bit");
        chk_bit(dup, 1'b1, "duplex on restart");
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word(r, 16'h1140, "restart self clear");
        $display("test duplex done");
    endtask

    task automatic t_aneg;
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h0100);
        chk_bit(aneg_rst, 1'b1, "restart on enable change");
        chk_bit(link_drop, 1'b1, "link broken");
        chk_bit(aneg_en, 1'b0, "enable off");
        fib_mode = FCR_MODE_100FX;
        cyc(2);
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h1100);
        chk_bit(aneg_rst, 1'b0, "no restart in 100FX");
        chk_bit(aneg_en, 1'b0, "no autoneg in 100FX");
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word(r, 16'h3100, "forced speed 100FX");
        $display("test aneg done");
    endtask

    task automatic t_loopback;
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h5100);
        chk_bit(lpbk, 1'b1, "loopback on");
        chk_bit(link_drop, 1'b1, "link down in loopback");
        chk_word({14'h0000, lpbk_spd}, {14'h0000, FCR_SPD_100}, "loopback 100");
        fib_mode = FCR_MODE_1000X;
        cyc(2);
        chk_word({14'h0000, lpbk_spd}, {14'h0000, FCR_SPD_1000}, "loopback 1000");
        chk_bit(link_drop, 1'b1, "link still down");
        $display("test loopback done");
    endtask

    task automatic t_soft_reset;
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h9000);
        chk_bit(fib_rst, 1'b1, "soft reset at once");
        chk_bit(aneg_rst, 1'b1, "restart on soft reset");
        chk_bit(lpbk, 1'b0, "loopback cleared");
        chk_bit(dup, 1'b0, "duplex on soft reset");
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word(r, 16'h9040, "reset bit busy");
        cyc(6);
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word(r, 16'h1040, "reset bit cleared");
        chk_bit(aneg_en, 1'b1, "enable kept");
        $display("test soft_reset done");
    endtask

    task automatic t_speed;
        logic [1:0] sp [3] = '{FCR_SPD_1000, FCR_SPD_100, FCR_SPD_10};
        fib_mode = FCR_MODE_AUTO;
        foreach (sp[i]) begin
            link_spd = sp[i];
            cyc(2);
            i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
            chk_word({14'h0000, r[6], r[13]}, {14'h0000, sp[i]}, "speed follows link");
            chk_word({14'h0000, spd}, {14'h0000, sp[i]}, "speed out");
        end
        fib_mode = FCR_MODE_SW;
        cyc(2);
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h3000);
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word({14'h0000, r[6], r[13]}, {14'h0000, FCR_SPD_100}, "speed writable");
        fib_mode = FCR_MODE_1000X;
        cyc(2);
        i_mgmt.wr(FCR_REG_FIBER_CTRL, 16'h34bf);
        i_mgmt.rd(FCR_REG_FIBER_CTRL, r);
        chk_word(r, 16'h1040, "forced bits ignored");
        $display("test speed done");
    endtask

    task automatic t_irq;
        logic [3:0] v [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'ha};
        i_mgmt.page(FCR_PAGE_COPPER);
        foreach (v[i]) begin
            port_irq = v[i];
            i_mgmt.rd(FCR_REG_IRQ_SUM, r);
            chk_word(r, {12'h000, v[i]}, "port summary");
        end
        i_mgmt.rd(5'h05, r);
        chk_word(r, 16'h0000, "unmapped read");
        $display("test irq done");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        pd_strap = 1'b1;
        an_strap = 1'b1;
        cfg_mode = 3'b010;
        fib_mode = FCR_MODE_1000X;
        link_spd = FCR_SPD_1000;
        port_irq = 4'h0;
        t_hw_reset;
        t_power_down_strap_exit;
        t_duplex;
        t_aneg;
        t_loopback;
        t_soft_reset;
        t_speed;
        t_irq;
        results;
    end

    // Watchdog over about nine times the expected run
    initial begin
        #(25 * 2000);
        err_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        results;
    end
endmodule
